// *** bench/daisy_chain_packet_handler_tb.sv ***
// Self-checking bench for the daisy-chain packet handler.
`timescale 1ns/1ps
module daisy_chain_packet_handler_tb import dcph_pkg::*;;
  logic        core_clk, reset, rx_valid, rx_ready, rx_framing, tx_valid, tx_ready, tx_framing;
  logic [7:0]  rx_data, tx_data, reg_addr;
  logic [4:0]  chain_position_id;
  logic        alive_counter_enable, skip_error_code_check, packet_error_clear;
  logic        diag_fault_alert_one, diag_fault_alert_two, overvoltage_alert;
  logic        undervoltage_alert, other_status_alert, packet_error_alert;
  logic        reg_addr_valid, reg_write;
  logic [15:0] reg_rdata, reg_wdata, wr_data;
  logic [1:0]  sink_mode;
  logic [7:0]  pin[$], pexp[$];
  int          err_total, checks, wr_cnt, n;

  // Register stand-in: the upper half of the map is unmapped.
  assign reg_addr_valid = reg_addr < 8'h80;
  assign reg_rdata      = {reg_addr, 8'h3c};

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  dcph_packet_handler #(.FIFO_DEPTH(16), .CRC_POLY(8'h07)) u_dut (.core_clk, .reset, .rx_valid,
    .rx_ready, .rx_data, .rx_framing, .tx_valid, .tx_ready, .tx_data, .tx_framing,
    .chain_position_id, .alive_counter_enable, .skip_error_code_check, .diag_fault_alert_one,
    .diag_fault_alert_two, .overvoltage_alert, .undervoltage_alert, .other_status_alert,
    .packet_error_clear, .packet_error_alert, .reg_addr, .reg_addr_valid, .reg_rdata,
    .reg_write, .reg_wdata);

  dcph_link_sink u_sink (.core_clk, .reset, .tx_valid, .tx_data, .tx_framing,
    .mode(sink_mode), .tx_ready);

  always @(posedge core_clk) begin
    if (reg_write === 1'b1) begin
      wr_cnt++;
      wr_data = reg_wdata;
    end
  end

  task automatic check_eq(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] crc(input logic [7:0] q[$], input int len);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < len; i++) begin
      c ^= q[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  task automatic put(input logic [7:0] d, input logic f);
    @(negedge core_clk);
    rx_valid   = 1'b1;
    rx_data    = d;
    rx_framing = f;
    while (rx_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
  endtask

  // Sends pin framed and compares the forwarded stream with pexp framed.
  task automatic xfer(input string what);
    u_sink.got.delete();
    put(PREAMBLE_CHAR, 1'b1);
    foreach (pin[i]) put(pin[i], 1'b0);
    put(STOP_CHAR, 1'b1);
    @(negedge core_clk);
    rx_valid = 1'b0;
    for (int w = 0; w < 300 && u_sink.got.size() < pexp.size() + 2; w++) @(negedge core_clk);
    check_eq(what, 16'(u_sink.got.size()), 16'(pexp.size() + 2));
    foreach (u_sink.got[i])
      check_eq(what, u_sink.got[i], i == 0 ? {1'b1, PREAMBLE_CHAR} :
               i > pexp.size() ? {1'b1, STOP_CHAR} : {1'b0, pexp[i-1]});
    check_eq("drain", tx_valid, 1'b0);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    {rx_valid, rx_data, rx_framing, skip_error_code_check, packet_error_clear, sink_mode} = '0;
    {diag_fault_alert_one, diag_fault_alert_two, overvoltage_alert, undervoltage_alert,
     other_status_alert} = '0;
    chain_position_id    = 5'h01;
    alive_counter_enable = 1'b1;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    pin    = '{BCAST_WRITE_CODE, 8'h10, 8'h34, 8'h12, 8'h00, 8'hff};
    pin[4] = crc(pin, 4);
    pexp   = pin;
    pexp[5] = 8'h00;
    xfer("bwrite");
    check_eq("wcount", 16'(wr_cnt), 16'h1);
    check_eq("wdata", wr_data, 16'h1234);
    for (int k = 0; k < 4; k++) begin
      skip_error_code_check = (k == 2);
      pin = '{{k == 1 ? 5'h02 : 5'h01, SINGLE_WRITE_SUFFIX}, 8'h11, 8'h5a, 8'(k), 8'h00, 8'h7f};
      pin[4] = crc(pin, 4) ^ (k > 1 ? 8'h01 : 8'h00);
      pexp = pin;
      pexp[5] = k == 1 ? 8'h7f : 8'h80;
      n = wr_cnt;
      xfer("swrite");
      check_eq("swcount", 16'(wr_cnt - n), (k == 1 || k == 3) ? 16'h0 : 16'h1);
      check_eq("alert", packet_error_alert, k == 3);
    end
    for (int k = 0; k < 3; k++) begin
      {diag_fault_alert_one, diag_fault_alert_two, overvoltage_alert, undervoltage_alert,
       other_status_alert} = k == 2 ? 5'b01011 : 5'b10100;
      if (k == 2) begin
        packet_error_clear = 1'b1;
        @(negedge core_clk);
        packet_error_clear = 1'b0;
        check_eq("cleared", packet_error_alert, 1'b0);
      end
      pin = '{{k == 1 ? 5'h03 : 5'h01, SINGLE_READ_SUFFIX}, 8'h22, 8'hc2, 8'hd3, 8'h19, 8'h00, 8'h05};
      pin[5] = crc(pin, 5);
      pexp = pin;
      if (k != 1) begin
        pexp[2] = 8'h3c;
        pexp[3] = 8'h22;
        pexp[4] = k == 0 ? 8'hfd : 8'h7b;
        pexp[5] = crc(pexp, 5);
        pexp[6] = 8'h06;
      end
      xfer("sread");
    end
    chain_position_id = 5'h09;
    for (int k = 0; k < 3; k++) begin
      pin = '{k == 1 ? ADDRESS_POLL_CODE : BCAST_READ_CODE, k == 2 ? 8'h90 : 8'h30};
      repeat (20) pin.push_back(8'hc2);
      pin = {pin, 8'h00, 8'h00, 8'h10};
      pin[23] = crc(pin, 23);
      pexp = pin;
      if (k != 2) begin
        pexp[20] = 8'h3c;
        pexp[21] = 8'h30;
        pexp[22] = 8'h62;
        pexp[23] = crc(pexp, 23);
        pexp[24] = 8'h11; // seed plus one device
      end
      sink_mode = k == 0 ? 2'd2 : 2'd1;
      fork
        xfer("bread");
        if (k == 0) begin
          repeat (60) @(negedge core_clk);
          check_eq("full", {rx_ready, tx_valid}, 2'b01);
          sink_mode = 2'd0;
        end
      join
    end
    sink_mode = 2'd0;
    alive_counter_enable = 1'b0;
    pin  = '{ADDRESS_ASSIGN_CODE, 8'h00, 8'h05};
    pexp = pin;
    xfer("assign");
    pin    = '{BCAST_WRITE_CODE, 8'h40, 8'hcd, 8'hab, 8'h00};
    pin[4] = crc(pin, 4);
    pexp   = pin;
    xfer("noalive");
    check_eq("wdata", wr_data, 16'habcd);
    check_eq("waddr", 16'(reg_addr), 16'h0040);
    give_verdict();
  end
endmodule

// *** bench/dcph_assertions.sv ***
// Port-level concurrent checks for the daisy-chain packet handler.
`timescale 1ns/1ps
module dcph_assertions (
  input wire logic       core_clk,              // Clock.
  input wire logic       reset,                 // Reset.
  input wire logic       rx_valid,              // Rx offer.
  input wire logic       rx_ready,              // Rx take.
  input wire logic       rx_framing,            // Rx framing.
  input wire logic       tx_valid,              // Tx offer.
  input wire logic       tx_ready,              // Tx take.
  input wire logic [7:0] tx_data,               // Tx byte.
  input wire logic       tx_framing,            // Tx framing.
  input wire logic       skip_error_code_check, // Check off.
  input wire logic       packet_error_clear,    // Alert clear.
  input wire logic       packet_error_alert,    // Alert.
  input wire logic [7:0] reg_addr,              // Address.
  input wire logic       reg_addr_valid,        // Address ok.
  input wire logic       reg_write              // Write strobe.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence framing_taken;
    rx_valid && rx_ready && rx_framing;
  endsequence

  sequence tx_stalled;
    tx_valid && !tx_ready;
  endsequence

  ready_drop_a: assert property (framing_taken |=> !rx_ready)
    else $error("rx_ready high right after a framing character");
  tx_hold_a: assert property (tx_stalled |=> tx_valid && $stable(tx_data) && $stable(tx_framing))
    else $error("offered character changed before it was taken");
  write_pulse_a: assert property (reg_write |=> !reg_write)
    else $error("write strobe longer than one cycle");
  write_valid_a: assert property (reg_write |-> reg_addr_valid && $stable(reg_addr))
    else $error("write to an invalid or moving address");
  write_flush_a: assert property (reg_write |-> !rx_ready)
    else $error("write strobe outside the end of a packet");
  alert_sticky_a: assert property (packet_error_alert && !packet_error_clear |=> packet_error_alert)
    else $error("error alert dropped without a clear");
  alert_clear_a: assert property ($fell(packet_error_alert) && !$past(reset) |-> $past(packet_error_clear))
    else $error("error alert fell without a clear");
  alert_skip_a: assert property ($rose(packet_error_alert) |-> !skip_error_code_check)
    else $error("error alert raised while the check is skipped");
endmodule

bind dcph_packet_handler dcph_assertions u_chk (.core_clk, .reset, .rx_valid, .rx_ready,
  .rx_framing, .tx_valid, .tx_ready, .tx_data, .tx_framing, .skip_error_code_check,
  .packet_error_clear, .packet_error_alert, .reg_addr, .reg_addr_valid, .reg_write);

// *** bench/dcph_link_sink.sv ***
// Far-side model: the next device's receiver, prompt, alternating or held.
`timescale 1ns/1ps
module dcph_link_sink (
  input  wire logic       core_clk,   // Clock.
  input  wire logic       reset,      // Reset.
  input  wire logic       tx_valid,   // Character offered.
  input  wire logic [7:0] tx_data,    // Character byte.
  input  wire logic       tx_framing, // Character is framing.
  input  wire logic [1:0] mode,       // 0 prompt, 1 alternate, 2 hold.
  output logic            tx_ready    // Character taken.
);
  logic [8:0] got[$];
  logic       tick;

  initial begin
    tx_ready = 1'b0;
    tick     = 1'b0;
  end

  // Ready moves on the falling edge so it never races the sampling edge.
  always @(negedge core_clk) begin
    tick     <= ~tick;
    tx_ready <= !reset && (mode == 2'd0 || (mode == 2'd1 && tick));
  end

  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back({tx_framing, tx_data});
    end
  end
endmodule

// *** logic/dcph_fifo.sv ***
// Intentionally empty: the link FIFO module is defined beside the packet handler.

// *** logic/dcph_packet_handler.sv ***
// Per-device command packet handler for a daisy-chained battery-monitor link.
`timescale 1ns/1ps
// Behaviour
// - Decode address-assign, address-poll, broadcast-write codes.
// - Broadcast read 03h; single commands carry address.
// - Ignore single commands for another chain position.
// - Invalid register address: skip access, forward unchanged.
// - One-byte register address, 16-bit two-byte data.
// - Data-check only in reads; single: addressed device.
// - OR own alert status into data-check byte.
// - Bits 7,6,2,1 and 5 map alert sources.
// - Check bits 4,3,0 forwarded as received.
// - Error code mismatch sets packet error alert.
// - All but address-assign carry CRC-8 error code.
// - Write only when received error code matches or skip_error_code_check is set.
// - Reads return recalculated error code over outgoing data.
// - Enabled alive counter ends non-assign packets.
// - Broadcast increments alive counter; single: addressed only.
// - Alive counter wraps modulo 256.
// - Error code excludes alive byte; increment regardless.
// - Broadcast read overwrites own fill pair.
// - Single read two fill bytes; writes pass unchanged but for alive byte.
// - Packet lengths fixed per command type.
// - Packets framed by preamble and stop characters.
// - Nibble characters, low first; bytes LSB first.
// - Validated write acts after error code byte.
module dcph_packet_handler import dcph_pkg::*; #(
  parameter int         FIFO_DEPTH = 16,
  parameter logic [7:0] CRC_POLY   = 8'h07
) (
  input  wire logic        core_clk,              // System clock, 20 MHz.
  input  wire logic        reset,                 // Synchronous reset, active high.
  input  wire logic        rx_valid,              // Received character offered.
  output logic             rx_ready,              // Character taken this cycle.
  input  wire logic [7:0]  rx_data,               // Received byte or framing code.
  input  wire logic        rx_framing,            // Character is a framing character.
  output logic             tx_valid,              // Forwarded character offered.
  input  wire logic        tx_ready,              // Transmitter takes the character.
  output logic [7:0]       tx_data,               // Forwarded byte or framing code.
  output logic             tx_framing,            // Forwarded character is framing.
  input  wire logic [4:0]  chain_position_id,     // This device's chain address.
  input  wire logic        alive_counter_enable,  // Packets carry an alive byte.
  input  wire logic        skip_error_code_check, // Writes proceed without check.
  input  wire logic        diag_fault_alert_one,  // Diagnostic fault one.
  input  wire logic        diag_fault_alert_two,  // Diagnostic fault two.
  input  wire logic        overvoltage_alert,     // Overvoltage status.
  input  wire logic        undervoltage_alert,    // Undervoltage status.
  input  wire logic        other_status_alert,    // Any other status alert.
  input  wire logic        packet_error_clear,    // Clears the packet error alert.
  output logic             packet_error_alert,    // Sticky error code mismatch flag.
  output logic [7:0]       reg_addr,              // Register address of the packet.
  input  wire logic        reg_addr_valid,        // Address is valid for this device.
  input  wire logic [15:0] reg_rdata,             // Read data of reg_addr.
  output logic             reg_write,             // One-cycle register write strobe.
  output logic [15:0]      reg_wdata              // Register write data.
);

  // Refused at elaboration: the FIFO needs at least two words.
  if (FIFO_DEPTH < 2) begin
    $error("FIFO depth must be at least two.");
  end

  // The last three bytes are held back: only the stop character tells which
  // of them are data-check, error code and alive counter in a broadcast read.
  typedef struct packed {
    logic [2:0][7:0] hold;
    logic [1:0]      count;
    logic            flushing;
    logic [7:0]      frame;
    logic [7:0]      cmd;
    logic [7:0]      reg_addr;
    logic [7:0]      in_idx;
    logic [7:0]      out_idx;
    logic [7:0]      rx_crc;
    logic [7:0]      tx_crc;
    logic [15:0]     wdata;
    logic            reg_write;
    logic            pec_alert;
  } dcph_state_t;

  dcph_state_t st;
  dcph_state_t next_st;

  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic [8:0] fifo_out_data;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  dcph_cmd_t  kind;
  logic       is_read;
  logic       is_write;
  logic       addressed;
  logic       act;
  logic [1:0] pec_pos;
  logic [1:0] dc_pos;
  logic [7:0] status_merge;
  logic [7:0] fill_lsb_idx;

  assign kind     = dcph_decode(st.cmd);
  assign is_read  = (kind == CMD_BREAD) || (kind == CMD_SREAD) || (kind == CMD_POLL);
  assign is_write = (kind == CMD_BWRITE) || (kind == CMD_SWRITE);
  assign addressed = ((kind == CMD_SREAD) || (kind == CMD_SWRITE))
                     ? (st.cmd[7:3] == chain_position_id) : (is_read || is_write);
  assign act      = addressed && reg_addr_valid;
  assign pec_pos  = alive_counter_enable ? 2'h2 : 2'h1;
  assign dc_pos   = pec_pos + 2'h1;
  assign fill_lsb_idx = (kind == CMD_SREAD) ? FIRST_FILL_INDEX
                        : 8'(FIRST_FILL_INDEX + {chain_position_id, 1'b0});

  always_comb begin
    status_merge                = '0;
    status_merge[DC_PEC_BIT]    = st.pec_alert;
    status_merge[DC_DIAG_BIT]   = diag_fault_alert_one || diag_fault_alert_two;
    status_merge[DC_STATUS_BIT] = other_status_alert || st.pec_alert;
    status_merge[DC_OV_BIT]     = overvoltage_alert;
    status_merge[DC_UV_BIT]     = undervoltage_alert;
  end

  always_comb begin
    logic       take;
    logic       emit;
    logic       emit_frame;
    logic [7:0] byte_in;
    logic [7:0] byte_out;
    logic [1:0] tail;
    logic       in_pec;
    logic       in_alive;
    logic       in_dc;
    logic       mismatch;
    take       = 1'b0;
    emit       = 1'b0;
    emit_frame = 1'b0;
    byte_in    = st.hold[0];
    byte_out   = st.hold[0];
    tail       = 2'h0;
    in_pec     = 1'b0;
    in_alive   = 1'b0;
    in_dc      = 1'b0;
    mismatch   = 1'b0;
    next_st           = st;
    next_st.reg_write = 1'b0;
    rx_ready          = fifo_in_ready && !st.flushing;

    if (st.flushing) begin
      if (st.count != '0) begin
        emit = fifo_in_ready;
        tail = st.count;
      end else if (fifo_in_ready) begin
        emit_frame       = 1'b1;
        next_st.flushing = 1'b0;
        if (st.frame == PREAMBLE_CHAR) begin
          next_st.cmd     = '0;
          next_st.in_idx  = '0;
          next_st.out_idx = '0;
          next_st.rx_crc  = CRC_INIT;
          next_st.tx_crc  = CRC_INIT;
        end
      end
    end else if (rx_valid && fifo_in_ready) begin
      take = 1'b1;
      if (rx_framing) begin
        next_st.flushing = 1'b1;
        next_st.frame    = rx_data;
      end else begin
        if (st.in_idx == CMD_INDEX) begin
          next_st.cmd = rx_data;
        end
        if (st.in_idx == REG_ADDR_INDEX) begin
          next_st.reg_addr = rx_data;
        end
        if (st.in_idx != INDEX_MAX) begin
          next_st.in_idx = st.in_idx + 8'h01;
        end
        emit = (st.count == HOLD_DEPTH);
      end
    end

    if (emit) begin
      in_pec   = (is_read || is_write) && (tail == pec_pos);
      in_alive = (is_read || is_write) && alive_counter_enable && (tail == ALIVE_TAIL_POS);
      in_dc    = is_read && (tail == dc_pos);
      mismatch = (byte_in != st.rx_crc);
      if (in_pec) begin
        if (act && mismatch && !skip_error_code_check) begin
          next_st.pec_alert = 1'b1;
        end
        if (is_read && act) begin
          byte_out = st.tx_crc;
        end
        if (is_write && act && (!mismatch || skip_error_code_check)) begin
          next_st.reg_write = 1'b1;
        end
      end else if (in_alive) begin
        if (act) begin
          byte_out = byte_in + ALIVE_STEP;
        end
      end else if (in_dc) begin
        if (act) begin
          byte_out = byte_in | status_merge;
        end
      end else begin
        if (is_read && act && st.out_idx == fill_lsb_idx) begin
          byte_out = reg_rdata[7:0];
        end else if (is_read && act && st.out_idx == 8'(fill_lsb_idx + 8'h01)) begin
          byte_out = reg_rdata[15:8];
        end
        if (is_write && st.out_idx == WDATA_LSB_INDEX) begin
          next_st.wdata[7:0] = byte_in;
        end
        if (is_write && st.out_idx == WDATA_MSB_INDEX) begin
          next_st.wdata[15:8] = byte_in;
        end
      end
      if (!in_pec && !in_alive) begin
        next_st.rx_crc = crc8_step(st.rx_crc, byte_in);
        next_st.tx_crc = crc8_step(st.tx_crc, byte_out);
      end
      if (st.out_idx != INDEX_MAX) begin
        next_st.out_idx = st.out_idx + 8'h01;
      end
    end

    if (emit) begin
      next_st.hold[0] = st.hold[1];
      next_st.hold[1] = st.hold[2];
      if (!take) begin
        next_st.count = st.count - 2'h1;
      end else begin
        next_st.hold[2] = rx_data;
      end
    end else if (take && !rx_framing) begin
      next_st.hold[st.count] = rx_data;
      next_st.count          = st.count + 2'h1;
    end

    // A new mismatch in the same cycle as a clear leaves the flag set only when it was clear before.
    if (packet_error_clear && !(next_st.pec_alert && !st.pec_alert)) begin
      next_st.pec_alert = 1'b0;
    end

    fifo_in_valid = emit || emit_frame;
    fifo_in_data  = emit_frame ? {1'b1, st.frame} : {1'b0, byte_out};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Back-pressure from the transmitter reaches rx_ready through the FIFO.
  dcph_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (fifo_out_data)
  );

  assign tx_data            = fifo_out_data[7:0];
  assign tx_framing         = fifo_out_data[8];
  assign packet_error_alert = st.pec_alert;
  assign reg_addr           = st.reg_addr;
  assign reg_write          = st.reg_write;
  assign reg_wdata          = st.wdata;
endmodule

// Flip-flop FIFO with valid/ready on both sides; the depth is a power of two.
module dcph_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,  // System clock.
  input  wire logic             reset,     // Synchronous reset, active high.
  input  wire logic             in_valid,  // Write side offers a word.
  output logic                  in_ready,  // FIFO has room.
  input  wire logic [WIDTH-1:0] in_data,   // Word to store.
  output logic                  out_valid, // FIFO holds a word.
  input  wire logic             out_ready, // Read side takes the word.
  output logic [WIDTH-1:0]      out_data   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so other depths would lose words.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("FIFO depth must be a power of two, at least two.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } dcph_fifo_state_t;

  dcph_fifo_state_t st;
  dcph_fifo_state_t next_st;
  logic             push;
  logic             pop;

  assign in_ready  = (st.count != DEPTH[AW:0]);
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** logic/dcph_pkg.sv ***
// Shared constants, command codes and types for the daisy-chain packet handler.
package dcph_pkg;

  localparam logic [7:0] ADDRESS_ASSIGN_CODE = 8'h57;
  localparam logic [7:0] ADDRESS_POLL_CODE   = 8'h01;
  localparam logic [7:0] BCAST_WRITE_CODE    = 8'h02;
  localparam logic [7:0] BCAST_READ_CODE     = 8'h03;
  localparam logic [2:0] SINGLE_WRITE_SUFFIX = 3'h4;
  localparam logic [2:0] SINGLE_READ_SUFFIX  = 3'h5;

  localparam logic [7:0] PREAMBLE_CHAR = 8'h15;
  localparam logic [7:0] STOP_CHAR     = 8'h54;

  // Data-check byte bit positions.
  localparam int DC_PEC_BIT    = 7;
  localparam int DC_DIAG_BIT   = 6;
  localparam int DC_STATUS_BIT = 5;
  localparam int DC_OV_BIT     = 2;
  localparam int DC_UV_BIT     = 1;

  localparam logic [7:0] FIRST_FILL_INDEX = 8'h02;
  localparam logic [7:0] CMD_INDEX        = 8'h00;
  localparam logic [7:0] REG_ADDR_INDEX   = 8'h01;
  localparam logic [7:0] WDATA_LSB_INDEX  = 8'h02;
  localparam logic [7:0] WDATA_MSB_INDEX  = 8'h03;
  localparam logic [7:0] INDEX_MAX        = 8'hff;
  localparam logic [7:0] CRC_INIT         = 8'h00;
  localparam logic [7:0] ALIVE_STEP       = 8'h01;
  localparam logic [1:0] HOLD_DEPTH       = 2'h3;
  localparam logic [1:0] ALIVE_TAIL_POS   = 2'h1;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ASSIGN,
    CMD_POLL,
    CMD_BWRITE,
    CMD_BREAD,
    CMD_SWRITE,
    CMD_SREAD
  } dcph_cmd_t;

  function automatic dcph_cmd_t dcph_decode(input logic [7:0] code);
    dcph_cmd_t kind;
    kind = CMD_NONE;
    if (code == ADDRESS_ASSIGN_CODE) begin
      kind = CMD_ASSIGN;
    end else if (code == ADDRESS_POLL_CODE) begin
      kind = CMD_POLL;
    end else if (code == BCAST_WRITE_CODE) begin
      kind = CMD_BWRITE;
    end else if (code == BCAST_READ_CODE) begin
      kind = CMD_BREAD;
    end else if (code[2:0] == SINGLE_WRITE_SUFFIX) begin
      kind = CMD_SWRITE;
    end else if (code[2:0] == SINGLE_READ_SUFFIX) begin
      kind = CMD_SREAD;
    end
    return kind;
  endfunction

endpackage
